// ==== design/flash_cmd_pkg.sv ====
// Constants for the flash status, quad mode and suspend command block.
// Assumes a 20 MHz system clock and a host that drives the serial link.
`default_nettype none
package flash_cmd_pkg;

  // Opcodes
  localparam logic [7:0] OPC_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] OPC_READ_STATUS    = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS   = 8'h01;
  localparam logic [7:0] OPC_READ_FUNCTION  = 8'h48;
  localparam logic [7:0] OPC_WRITE_FUNCTION = 8'h42;
  localparam logic [7:0] OPC_ENTER_QUAD     = 8'h35;
  localparam logic [7:0] OPC_EXIT_QUAD      = 8'hf5;
  localparam logic [7:0] OPC_SUSPEND_A      = 8'h75;
  localparam logic [7:0] OPC_SUSPEND_B      = 8'hb0;
  localparam logic [7:0] OPC_RESUME_A       = 8'h7a;
  localparam logic [7:0] OPC_RESUME_B       = 8'h30;

  // Status byte fields
  localparam int SR_WIP_BIT  = 0;
  localparam int SR_WEL_BIT  = 1;
  localparam int SR_BP_LSB   = 2;
  localparam int SR_BP_W     = 4;
  localparam int SR_QE_BIT   = 6;
  localparam int SR_STATUS_WRITE_PROTECT_BIT_BIT = 7;

  // Function byte fields
  localparam int FR_RSTDIS_BIT = 1;
  localparam int FR_PROGRAM_SUSPENDED_BIT_BIT   = 2;
  localparam int FR_ERASE_SUSPENDED_BIT_BIT   = 3;
  localparam int FR_IRL_LSB    = 4;
  localparam int FR_IRL_W      = 4;

  // Reset values
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [7:0] FUNCTION_RESET = 8'h00;

  // Timing
  localparam int CLK_HZ             = 20_000_000;
  localparam int SUSPEND_LATENCY_US = 100;
  localparam int RESUME_GAP_US      = 400;
  // Longest time rounds down, least time rounds up
  localparam int SUSPEND_LATENCY_CYC =
    (SUSPEND_LATENCY_US * (CLK_HZ / 1_000_000) > 0) ?
    SUSPEND_LATENCY_US * (CLK_HZ / 1_000_000) : 1;
  // Cycles per microsecond first, so the product stays inside 32 bits
  localparam int RESUME_GAP_CYC =
    RESUME_GAP_US * ((CLK_HZ + 999_999) / 1_000_000);

  // Internal write operation in flight
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_PROGRAM,
    OP_ERASE,
    OP_REG_WRITE,
    OP_SUSPENDING
  } op_state_t;

endpackage

`default_nettype wire

// ==== design/flash_cmd_core.sv ====
// Command interpreter for write enable/disable, status and function
// register access, quad peripheral mode and program/erase suspend.
// Assumes the host clocks the link on sck_i only while cs_n_i is low,
// and keeps cs_n_i high for at least four clk_i cycles between frames.
`timescale 1ns/10ps
`default_nettype none

module flash_cmd_core
  import flash_cmd_pkg::*;
#(
  parameter int PAGE_PROGRAM_CYC = 16000,
  parameter int SECTOR_ERASE_CYC = 60000,
  parameter int BLOCK_ERASE_CYC  = 200000,
  parameter int REG_WRITE_CYC    = 4000,
  parameter int RESUME_GAP_CYCLES = flash_cmd_pkg::RESUME_GAP_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_o,
  input  wire logic       rst_pin_n_i,
  input  wire logic       program_start_i,
  input  wire logic       erase_start_i,
  input  wire logic       erase_block_i,
  output logic            write_in_progress_flag_o,
  output logic            write_enable_latch_o,
  output logic            quad_mode_o,
  output logic            array_write_active_o,
  output logic      [7:0] status_o,
  output logic      [7:0] function_o
);

  // Refuse counts that the down-counters cannot serve
  if (PAGE_PROGRAM_CYC < 1 || SECTOR_ERASE_CYC < 1 ||
      BLOCK_ERASE_CYC < 1 || REG_WRITE_CYC < 1 ||
      RESUME_GAP_CYCLES < 1) begin : gen_bad_counts
    $error("flash_cmd_core: cycle counts must be at least one");
  end

  // System clock domain state
  op_state_t   op_reg;
  op_state_t   op_resume_reg;
  logic [31:0] op_cnt_reg;
  logic [31:0] prog_left_reg;
  logic [31:0] erase_left_reg;
  logic [31:0] gap_cnt_reg;
  logic        wel_reg;
  logic [3:0]  bp_reg;
  logic        qe_reg;
  logic        status_write_protect_bit_reg;
  logic        rstdis_reg;
  logic [3:0]  irl_reg;
  logic        program_suspended_bit_reg;
  logic        erase_suspended_bit_reg;
  logic        link_rst_reg;
  logic [2:0]  cs_sync_reg;
  logic        cs_high_reg;
  logic [2:0]  rp_sync_reg;
  logic [2:0]  quad_sync_reg;
  logic        quad_seen_reg;
  logic [7:0]  status_byte;
  logic [7:0]  function_byte;

  // Link clock domain state
  logic [2:0]  bit_cnt_reg;
  logic [6:0]  shift_reg;
  logic        first_reg;
  logic [7:0]  opcode_reg;
  logic        opcode_ok_reg;
  logic [7:0]  opc_hold_reg;
  logic [7:0]  data_hold_reg;
  logic [1:0]  nbytes_reg;
  logic        quad_reg;
  logic [7:0]  sr_lnk1_reg;
  logic [7:0]  sr_lnk2_reg;
  logic [7:0]  fr_lnk1_reg;
  logic [7:0]  fr_lnk2_reg;
  logic [7:0]  out_sh_reg;
  logic [2:0]  out_cnt_reg;
  logic        out_en_reg;

  logic        byte_done;
  logic [7:0]  byte_val;
  logic        read_active;

  // Link side: a byte is eight serial bits or two nibbles
  assign byte_done = quad_reg ? (bit_cnt_reg == 3'h1)
                              : (bit_cnt_reg == 3'h7);
  assign byte_val  = quad_reg ? {shift_reg[3:0], io_i}
                              : {shift_reg, io_i[0]};
  assign read_active = opcode_ok_reg &&
                       (opcode_reg == OPC_READ_STATUS ||
                        opcode_reg == OPC_READ_FUNCTION);

  // Frame bit counter; chip select high ends any frame at once
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 7'h00;
      first_reg     <= 1'b1;
      opcode_reg    <= 8'h00;
      opcode_ok_reg <= 1'b0;
    end else begin
      shift_reg   <= quad_reg ? {shift_reg[2:0], io_i}
                              : {shift_reg[5:0], io_i[0]};
      bit_cnt_reg <= byte_done ? 3'h0 : bit_cnt_reg + 3'h1;
      if (byte_done && first_reg) begin
        first_reg     <= 1'b0;
        opcode_reg    <= byte_val;
        opcode_ok_reg <= 1'b1;
      end
    end
  end

  // Frame words held for the system side, stable once sck stops
  always_ff @(posedge sck_i or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      opc_hold_reg  <= 8'h00;
      data_hold_reg <= 8'h00;
      nbytes_reg    <= 2'h0;
    end else if (byte_done) begin
      if (first_reg) begin
        opc_hold_reg <= byte_val;
        nbytes_reg   <= 2'h1;
      end else if (nbytes_reg == 2'h1) begin
        data_hold_reg <= byte_val;
        nbytes_reg    <= 2'h2;
      end else begin
        nbytes_reg <= 2'h3;
      end
    end else if (first_reg && bit_cnt_reg == 3'h0) begin
      // A new frame must not replay the previous one
      nbytes_reg <= 2'h0;
    end
  end

  // Quad mode is tracked on the link so the next frame sees it at once
  always_ff @(posedge sck_i or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      quad_reg <= 1'b0;
    end else if (byte_done && first_reg) begin
      if (!quad_reg && byte_val == OPC_ENTER_QUAD) begin
        quad_reg <= 1'b1;
      end else if (quad_reg && byte_val == OPC_EXIT_QUAD) begin
        quad_reg <= 1'b0;
      end
    end
  end

  // Register images into the link domain; each bit is a lone level
  always_ff @(posedge sck_i or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      sr_lnk1_reg <= STATUS_RESET;
      sr_lnk2_reg <= STATUS_RESET;
      fr_lnk1_reg <= FUNCTION_RESET;
      fr_lnk2_reg <= FUNCTION_RESET;
    end else begin
      sr_lnk1_reg <= status_byte;
      sr_lnk2_reg <= sr_lnk1_reg;
      fr_lnk1_reg <= function_byte;
      fr_lnk2_reg <= fr_lnk1_reg;
    end
  end

  // Read data leaves on falling sck; status repeats while clocked
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_sh_reg  <= 8'h00;
      out_cnt_reg <= 3'h0;
      out_en_reg  <= 1'b0;
    end else if (read_active) begin
      out_en_reg <= 1'b1;
      if (!out_en_reg || out_cnt_reg == (quad_reg ? 3'h1 : 3'h7)) begin
        out_cnt_reg <= 3'h0;
        out_sh_reg  <= (opcode_reg == OPC_READ_STATUS)
                       ? sr_lnk2_reg
                       : fr_lnk2_reg;
      end else begin
        out_cnt_reg <= out_cnt_reg + 3'h1;
        out_sh_reg  <= quad_reg ? {out_sh_reg[3:0], 4'h0}
                                : {out_sh_reg[6:0], 1'b0};
      end
    end
  end

  // Pins: serial output on io[1], quad output high nibble first
  always_comb begin
    if (quad_reg) begin
      io_o    = out_sh_reg[7:4];
      io_oe_o = out_en_reg ? 4'hf : 4'h0;
    end else begin
      io_o    = {2'b00, out_sh_reg[7], 1'b0};
      io_oe_o = out_en_reg ? 4'h2 : 4'h0;
    end
  end

  // Chip select, reset pin and quad flag pass three flops; agreement counts
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs_sync_reg   <= 3'b111;
      cs_high_reg   <= 1'b1;
      rp_sync_reg   <= 3'b111;
      quad_sync_reg <= 3'b000;
      quad_seen_reg <= 1'b0;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[1:0], cs_n_i};
      rp_sync_reg   <= {rp_sync_reg[1:0], rst_pin_n_i};
      quad_sync_reg <= {quad_sync_reg[1:0], quad_reg};
      if (cs_sync_reg[1] == cs_sync_reg[2]) begin
        cs_high_reg <= cs_sync_reg[2];
      end
      if (quad_sync_reg[1] == quad_sync_reg[2]) begin
        quad_seen_reg <= quad_sync_reg[2];
      end
    end
  end

  logic frame_end;
  logic pin_reset;
  logic [7:0] cmd;
  logic cmd_valid;
  logic is_suspend;
  logic is_resume;
  logic busy;
  logic suspended;

  assign frame_end  = !cs_high_reg && cs_sync_reg[1] && cs_sync_reg[2];
  assign pin_reset  = !rp_sync_reg[1] && !rp_sync_reg[2] &&
                      !rstdis_reg;
  assign cmd        = opc_hold_reg;
  assign cmd_valid  = frame_end && nbytes_reg != 2'h0;
  assign is_suspend = cmd == OPC_SUSPEND_A ||
                      cmd == OPC_SUSPEND_B;
  assign is_resume  = cmd == OPC_RESUME_A ||
                      cmd == OPC_RESUME_B;
  assign busy       = op_reg != OP_IDLE;
  assign suspended  = program_suspended_bit_reg || erase_suspended_bit_reg;

  // Link domain is held in reset with the system and by the reset pin
  always_ff @(posedge clk_i) begin
    link_rst_reg <= sys_rst_i || pin_reset;
  end

  logic suspend_ok;
  logic resume_ok;
  logic array_start_ok;
  logic reg_write_ok;

  assign suspend_ok = cmd_valid && is_suspend && gap_cnt_reg == 32'h0 &&
                      (op_reg == OP_PROGRAM ||
                       op_reg == OP_ERASE);
  assign resume_ok  = cmd_valid && is_resume && !busy && suspended;
  // Program is also allowed inside an erase suspend
  assign array_start_ok = !busy && wel_reg && !program_suspended_bit_reg;
  assign reg_write_ok   = cmd_valid && !busy && !suspended && wel_reg &&
                          nbytes_reg == 2'h2;

  // Internal write sequencer with remaining time kept over a suspend
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || pin_reset) begin
      op_reg         <= OP_IDLE;
      op_resume_reg  <= OP_IDLE;
      op_cnt_reg     <= 32'h0;
      prog_left_reg  <= 32'h0;
      erase_left_reg <= 32'h0;
      program_suspended_bit_reg       <= 1'b0;
      erase_suspended_bit_reg       <= 1'b0;
    end else begin
      unique case (op_reg)
        OP_IDLE: begin
          if (resume_ok) begin
            // Innermost suspension resumes first
            if (program_suspended_bit_reg) begin
              program_suspended_bit_reg   <= 1'b0;
              op_reg     <= OP_PROGRAM;
              op_cnt_reg <= prog_left_reg;
            end else begin
              erase_suspended_bit_reg   <= 1'b0;
              op_reg     <= OP_ERASE;
              op_cnt_reg <= erase_left_reg;
            end
          end else if (reg_write_ok &&
                       (cmd == OPC_WRITE_STATUS ||
                        cmd == OPC_WRITE_FUNCTION)) begin
            op_reg     <= OP_REG_WRITE;
            op_cnt_reg <= REG_WRITE_CYC[31:0];
          end else if (program_start_i && array_start_ok) begin
            op_reg     <= OP_PROGRAM;
            op_cnt_reg <= PAGE_PROGRAM_CYC[31:0];
          end else if (erase_start_i && array_start_ok && !erase_suspended_bit_reg) begin
            op_reg     <= OP_ERASE;
            op_cnt_reg <= erase_block_i ? BLOCK_ERASE_CYC[31:0]
                                        : SECTOR_ERASE_CYC[31:0];
          end
        end
        OP_PROGRAM, OP_ERASE: begin
          if (suspend_ok) begin
            op_reg        <= OP_SUSPENDING;
            op_resume_reg <= op_reg;
            op_cnt_reg    <= SUSPEND_LATENCY_CYC[31:0];
            if (op_reg == OP_PROGRAM) begin
              program_suspended_bit_reg      <= 1'b1;
              prog_left_reg <= op_cnt_reg;
            end else begin
              erase_suspended_bit_reg       <= 1'b1;
              erase_left_reg <= op_cnt_reg;
            end
          end else if (op_cnt_reg <= 32'h1) begin
            op_reg <= OP_IDLE;
          end else begin
            op_cnt_reg <= op_cnt_reg - 32'h1;
          end
        end
        OP_REG_WRITE, OP_SUSPENDING: begin
          if (op_cnt_reg <= 32'h1) begin
            op_reg <= OP_IDLE;
          end else begin
            op_cnt_reg <= op_cnt_reg - 32'h1;
          end
        end
      endcase
    end
  end

  // Least spacing from a resume to the next suspend
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || pin_reset) begin
      gap_cnt_reg <= 32'h0;
    end else if (resume_ok) begin
      gap_cnt_reg <= RESUME_GAP_CYCLES[31:0];
    end else if (gap_cnt_reg != 32'h0) begin
      gap_cnt_reg <= gap_cnt_reg - 32'h1;
    end
  end

  logic write_done;
  assign write_done = op_cnt_reg <= 32'h1 &&
                      (op_reg == OP_PROGRAM || op_reg == OP_ERASE ||
                       op_reg == OP_REG_WRITE) && !suspend_ok;

  // Write enable latch; finishing a write outranks a new set
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || pin_reset) begin
      wel_reg <= 1'b0;
    end else if (write_done) begin
      wel_reg <= 1'b0;
    end else if (suspend_ok) begin
      wel_reg <= 1'b0;
    end else if (cmd_valid && cmd == OPC_WRITE_DISABLE && !busy) begin
      wel_reg <= 1'b0;
    end else if (cmd_valid && cmd == OPC_WRITE_ENABLE && !busy &&
                 !program_suspended_bit_reg) begin
      wel_reg <= 1'b1;
    end
  end

  // Non-volatile status bits; only a system reset models a fresh part
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bp_reg   <= STATUS_RESET[SR_BP_LSB +: SR_BP_W];
      qe_reg   <= STATUS_RESET[SR_QE_BIT];
      status_write_protect_bit_reg <= STATUS_RESET[SR_STATUS_WRITE_PROTECT_BIT_BIT];
    end else if (reg_write_ok && cmd == OPC_WRITE_STATUS) begin
      bp_reg   <= data_hold_reg[SR_BP_LSB +: SR_BP_W];
      status_write_protect_bit_reg <= data_hold_reg[SR_STATUS_WRITE_PROTECT_BIT_BIT];
      qe_reg   <= data_hold_reg[SR_QE_BIT];
    end
  end

  // One-time bits can only be ORed in, never cleared by software
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rstdis_reg <= FUNCTION_RESET[FR_RSTDIS_BIT];
      irl_reg    <= FUNCTION_RESET[FR_IRL_LSB +: FR_IRL_W];
    end else if (reg_write_ok && cmd == OPC_WRITE_FUNCTION) begin
      rstdis_reg <= rstdis_reg |
                    data_hold_reg[FR_RSTDIS_BIT];
      irl_reg    <= irl_reg |
                    data_hold_reg[FR_IRL_LSB +: FR_IRL_W];
    end
  end

  // Byte images; progress flag covers writes and suspend settling
  always_comb begin
    status_byte                        = 8'h00;
    status_byte[SR_WIP_BIT]            = busy;
    status_byte[SR_WEL_BIT]            = wel_reg;
    status_byte[SR_BP_LSB +: SR_BP_W]  = bp_reg;
    status_byte[SR_QE_BIT]             = qe_reg;
    status_byte[SR_STATUS_WRITE_PROTECT_BIT_BIT]           = status_write_protect_bit_reg;
    function_byte                      = 8'h00;
    function_byte[FR_RSTDIS_BIT]       = rstdis_reg;
    function_byte[FR_PROGRAM_SUSPENDED_BIT_BIT]         = program_suspended_bit_reg;
    function_byte[FR_ERASE_SUSPENDED_BIT_BIT]         = erase_suspended_bit_reg;
    function_byte[FR_IRL_LSB +: FR_IRL_W] = irl_reg;
  end

  // Status outputs from registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_o             <= STATUS_RESET;
      function_o           <= FUNCTION_RESET;
      array_write_active_o <= 1'b0;
    end else begin
      status_o             <= status_byte;
      function_o           <= function_byte;
      array_write_active_o <= op_reg == OP_PROGRAM || op_reg == OP_ERASE;
    end
  end

  assign write_in_progress_flag_o = status_o[SR_WIP_BIT];
  assign write_enable_latch_o     = status_o[SR_WEL_BIT];
  assign quad_mode_o              = quad_seen_reg;

endmodule // flash_cmd_core

`default_nettype wire

// ==== tb/flash_host_model.sv ====
// Host side of the serial link: frames commands in SPI or quad cycles.
// Assumes the bench resolves the shared data lines and feeds io_i.
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
  output logic            sck_o,
  output logic            cs_n_o,
  output logic      [3:0] io_o,
  input  wire logic [3:0] io_i
);
  // Link clock stands low outside frames
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h5;
  end

  // Data set while the clock is low, taken on the rise
  task automatic put(input logic [3:0] v);
    io_o = v;
    #24 sck_o = 1'b1;
    #24 sck_o = 1'b0;
  endtask

  // Opcode, optional data byte, optional read byte
  task automatic xfer(input logic [7:0] op, input logic [7:0] dat,
                      input int nb, input bit rd, input bit quad,
                      output logic [7:0] rb);
    logic [7:0] b;
    rb = 8'h00;
    cs_n_o = 1'b0;
    #24;
    for (int i = 0; i <= nb; i++) begin
      b = (i == 0) ? op : dat;
      if (quad) begin
        put(b[7:4]);
        put(b[3:0]);
      end else begin
        for (int j = 7; j >= 0; j--) put({~io_o[3:1], b[j]});
      end
    end
    // Released lines toggle so a stale value cannot pass for data
    io_o = ~io_o;
    for (int j = 0; rd && j < (quad ? 2 : 8); j++) begin
      #24 sck_o = 1'b1;
      rb = quad ? {rb[3:0], io_i} : {rb[6:0], io_i[1]};
      #24 sck_o = 1'b0;
    end
    #24 cs_n_o = 1'b1;
    io_o = ~io_o;
    #400; // Frame gap well above four system clocks
  endtask
endmodule // flash_host_model
`default_nettype wire

// ==== tb/flash_cmd_core_properties.sv ====
// Concurrent checks on the command block's outputs.
// Assumes it is bound to flash_cmd_core; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_core_properties (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       program_start_i,
  input wire logic [3:0] io_oe_o,
  input wire logic       write_in_progress_flag_o,
  input wire logic       write_enable_latch_o,
  input wire logic       quad_mode_o,
  input wire logic       array_write_active_o,
  input wire logic [7:0] status_o,
  input wire logic [7:0] function_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Entry into each kind of suspend
  sequence prog_susp_s;
    $rose(function_o[2]);
  endsequence
  sequence erase_susp_s;
    $rose(function_o[3]);
  endsequence

  wip_mirror_a: assert property (
    array_write_active_o |-> write_in_progress_flag_o)
    else $error("array write running while progress flag is low");
  otp_sticky_a: assert property (
    1'b1 |=> ((function_o & $past(function_o) & 8'hf2) ==
              ($past(function_o) & 8'hf2)))
    else $error("one-time bit returned to zero");
  prog_susp_a: assert property (
    prog_susp_s |-> ##[0:2] (!write_enable_latch_o && !array_write_active_o))
    else $error("program suspend left latch or array running");
  erase_susp_a: assert property (
    erase_susp_s |-> ##[0:2] !write_enable_latch_o)
    else $error("erase suspend left latch set");
  susp_busy_a: assert property (
    prog_susp_s or erase_susp_s |-> ##[0:2] write_in_progress_flag_o [*8])
    else $error("suspend did not hold busy");
  resume_run_a: assert property (
    $fell(function_o[2]) |-> ##[0:3] array_write_active_o)
    else $error("resume did not restart program");
  done_latch_a: assert property (
    $fell(array_write_active_o) |-> ##[0:2] !write_enable_latch_o)
    else $error("latch still set after write ended");
  start_latch_a: assert property (
    (program_start_i && !write_enable_latch_o && !array_write_active_o)
      |-> ##2 !array_write_active_o)
    else $error("program started without latch");
  quad_oe_a: assert property (
    (io_oe_o == 4'hf) |-> quad_mode_o)
    else $error("four-line drive outside quad mode");
endmodule // flash_cmd_core_properties

bind flash_cmd_core flash_cmd_core_properties flash_cmd_core_properties_i (
  .clk_i, .sys_rst_i, .program_start_i, .io_oe_o, .write_in_progress_flag_o,
  .write_enable_latch_o, .quad_mode_o, .array_write_active_o, .status_o,
  .function_o);
`default_nettype wire

// ==== tb/flash_cmd_core_tb_top.sv ====
// Self-checking bench: host model on the link, expected bytes kept here.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_core_tb_top;
  import flash_cmd_pkg::*;
  localparam int PP = 200;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, rst_pin_n_i = 1'b1;
  logic program_start_i = 1'b0, erase_start_i = 1'b0, erase_block_i = 1'b0;
  logic write_in_progress_flag_o, write_enable_latch_o, quad_mode_o;
  logic array_write_active_o;
  logic [3:0] host_io, io_o, io_oe_o;
  logic [7:0] status_o, function_o, rb, d;
  wire logic sck_i, cs_n_i;
  wire logic [3:0] io_i = (io_oe_o & io_o) | (~io_oe_o & host_io);
  int n_fail = 0, num_checks = 0, sr_m = 0, fr_m = 0, k, act = 0;
  bit qm = 1'b0;
  logic [7:0] sus [2] = '{OPC_SUSPEND_A, OPC_SUSPEND_B};
  logic [7:0] res [2] = '{OPC_RESUME_A, OPC_RESUME_B};

  flash_cmd_core #(.PAGE_PROGRAM_CYC(PP), .SECTOR_ERASE_CYC(300),
    .BLOCK_ERASE_CYC(400), .REG_WRITE_CYC(60), .RESUME_GAP_CYCLES(100))
  flash_cmd_core_i (.clk_i, .sys_rst_i, .sck_i, .cs_n_i, .io_i, .io_o,
    .io_oe_o, .rst_pin_n_i, .program_start_i, .erase_start_i,
    .erase_block_i, .write_in_progress_flag_o, .write_enable_latch_o,
    .quad_mode_o, .array_write_active_o, .status_o, .function_o);
  flash_host_model flash_host_model_i (.sck_o(sck_i), .cs_n_o(cs_n_i),
    .io_o(host_io), .io_i(io_i));

  // System clock, 50 ns
  always #25 clk_i = ~clk_i;
  // Array time counted off the edge so the restart at posedge never races
  always @(negedge clk_i) if (array_write_active_o === 1'b1) act++;

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input int nb = 0,
                     input logic [7:0] dd = 8'h00);
    flash_host_model_i.xfer(op, dd, nb, 1'b0, qm, rb);
  endtask
  task automatic rd(input logic [7:0] op, input int e);
    flash_host_model_i.xfer(op, 8'h00, 0, 1'b1, qm, rb);
    check(rb, 8'(e));
  endtask
  task automatic wait_idle();
    for (k = 0; k < 6000 && write_in_progress_flag_o !== 1'b0; k++)
      @(posedge clk_i);
  endtask
  task automatic pulse(input bit er);
    @(posedge clk_i);
    if (er) erase_start_i <= 1'b1;
    else program_start_i <= 1'b1;
    act = 0;
    @(posedge clk_i);
    erase_start_i <= 1'b0;
    program_start_i <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    k = $urandom(32'h6e424e53);
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(status_o, 8'h00);
    check(function_o, 8'h00);
    d = 8'($urandom);
    cmd(OPC_WRITE_ENABLE);
    cmd(OPC_WRITE_STATUS, 1, d);
    sr_m = d & 8'hfc;
    rd(OPC_READ_STATUS, sr_m | 3);
    wait_idle();
    check(status_o, 8'(sr_m));
    cmd(OPC_WRITE_ENABLE);
    cmd(OPC_WRITE_DISABLE);
    pulse(1'b0);
    check(status_o, 8'(sr_m));
    d = 8'($urandom) | 8'h02;
    cmd(OPC_WRITE_ENABLE);
    cmd(OPC_WRITE_FUNCTION, 1, d);
    wait_idle();
    fr_m = d & 8'hf2;
    rd(OPC_READ_FUNCTION, fr_m);
    cmd(OPC_WRITE_ENABLE);
    cmd(OPC_WRITE_FUNCTION, 1, 8'h00);
    wait_idle();
    check(function_o, 8'(fr_m));
    cmd(OPC_WRITE_ENABLE);
    @(posedge clk_i) rst_pin_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_pin_n_i <= 1'b1;
    check(status_o, 8'(sr_m | 2));
    // Program suspend with each opcode pair; early re-suspend refused
    for (int i = 0; i < 2; i++) begin
      cmd(OPC_WRITE_ENABLE);
      pulse(1'b0);
      cmd(sus[i]);
      fr_m |= 4;
      check(function_o, 8'(fr_m));
      check(status_o, 8'(sr_m | 1));
      wait_idle();
      cmd(OPC_WRITE_ENABLE);
      rd(OPC_READ_STATUS, sr_m);
      cmd(res[i]);
      fr_m &= ~4;
      cmd(sus[i]);
      check(function_o, 8'(fr_m));
      wait_idle();
      check(8'(act >= PP - 2 && act <= PP + 2), 8'h01);
      check(status_o, 8'(sr_m));
    end
    cmd(OPC_EXIT_QUAD);
    check(8'(quad_mode_o), 8'h00);
    cmd(OPC_ENTER_QUAD);
    qm = 1'b1;
    check(8'(quad_mode_o), 8'h01);
    // Erase suspend in quad mode with a nested program suspend
    cmd(OPC_WRITE_ENABLE);
    @(posedge clk_i) erase_block_i <= 1'($urandom);
    pulse(1'b1);
    cmd(OPC_SUSPEND_B);
    fr_m |= 8;
    check(function_o, 8'(fr_m));
    check(status_o, 8'(sr_m | 1));
    wait_idle();
    rd(OPC_READ_FUNCTION, fr_m);
    cmd(OPC_WRITE_ENABLE);
    pulse(1'b0);
    cmd(OPC_SUSPEND_A);
    fr_m |= 4;
    check(function_o, 8'(fr_m));
    wait_idle();
    cmd(OPC_RESUME_B);
    fr_m &= ~4;
    check(function_o, 8'(fr_m));
    wait_idle();
    cmd(OPC_RESUME_A);
    fr_m &= ~8;
    wait_idle();
    check(function_o, 8'(fr_m));
    check(status_o, 8'(sr_m));
    cmd(OPC_EXIT_QUAD);
    qm = 1'b0;
    check(8'(quad_mode_o), 8'h00);
    conclude();
  end

  // Watchdog well beyond the expected run of about 10000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    conclude();
  end
endmodule // flash_cmd_core_tb_top
`default_nettype wire
